// *** pkg/frv_pkg.sv ***
// Shared constants and carrier types of the flash range verify block
package frv_pkg;
  // Register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_FIRST = 5'h04;
  localparam logic [4:0] REG_LAST = 5'h08;
  localparam logic [4:0] REG_BUF_BASE = 5'h0C;
  localparam logic [4:0] REG_PIN_CFG = 5'h10;
  localparam logic [4:0] REG_STATUS = 5'h14;
  localparam logic [4:0] REG_NEXT = 5'h18;
  // Control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_SEND_BIT = 1;
  localparam int CTRL_OPT_LSB = 8;
  localparam int CTRL_TXB_LSB = 16;
  // Pin configuration fields
  localparam int PIN_DIR_BIT = 0;
  localparam int PIN_DATA_BIT = 1;
  // Status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_RESULT_BIT = 2;
  localparam int ST_SETUP_ERR_BIT = 3;
  localparam int ST_PIN_BIT = 4;
  localparam int ST_CSUM_LSB = 8;
  // Option value that selects send-out
  localparam logic [7:0] OPT_SEND_OUT = 8'h00;
  // Reset values
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // Serial timing: bit period is the operating clock divided by 256
  localparam int BAUD_DIV = 256;
  localparam logic [7:0] BAUD_LAST = 8'(BAUD_DIV - 1);
  localparam int FRAME_BITS = 10;
  localparam logic [3:0] FRAME_LAST = 4'(FRAME_BITS - 1);
  // Watchdog service: first after 24 cycles, then every period
  localparam int WDOG_FIRST_CYC = 24;
  localparam int WDOG_PERIOD_CYC = 64;
  localparam logic [7:0] WDOG_FIRST = 8'(WDOG_FIRST_CYC - 1);
  localparam logic [7:0] WDOG_PERIOD = 8'(WDOG_PERIOD_CYC - 1);
  // Buffer between flash reads and the serial sender
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 32;

  typedef struct packed {
    logic rd;
    logic [15:0] addr;
  } frv_flash_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } frv_buf_req_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_FLASH_RD = 4'h1,
    ST_FLASH_WAIT = 4'h2,
    ST_BUF_RD = 4'h3,
    ST_BUF_WAIT = 4'h4,
    ST_BUF_WR = 4'h5,
    ST_PUSH = 4'h6,
    ST_NEXT = 4'h7,
    ST_DRAIN = 4'h8,
    ST_SINGLE = 4'h9,
    ST_SINGLE_DRAIN = 4'hA
  } frv_state_t;
endpackage

// *** hdl/frv_top.sv ***
// Flash range verify and send-out engine with its FIFO and bus slave
`timescale 1ns/1ns

module frv_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = mem[rd_ptr_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= AW'(wr_ptr_q + 1'b1);
      end
      if (pop) begin
        rd_ptr_q <= AW'(rd_ptr_q + 1'b1);
      end
      if (push && !pop) begin
        count_q <= (AW+1)'(count_q + 1'b1);
      end else if (pop && !push) begin
        count_q <= (AW+1)'(count_q - 1'b1);
      end
    end
  end
endmodule

// Notes on behaviour
// - Option byte zero selects send-out; any other value selects compare.
// - Read every flash byte from first to last address, ascending.
// - Compare mode checks each byte, then overwrites the buffer entry.
// - Result flag set if all bytes matched, cleared on any mismatch.
// - Send-out does no comparison; result flag then has no meaning.
// - Checksum is the low eight bits of the sum of all read bytes.
// - Next address returned is the one after the last range byte.
// - Send-out transmits each read byte on the link pin at send baud.
// - Bit period is the operating clock divided by 256.
// - NRZ frames with a low start bit and a high stop bit.
// - Pin must be input with data latch zero before sending starts.
// - Watchdog serviced during operation, first 24 cycles after start; the code does not service it during a single-byte send.
// - Interrupts stay unmasked for the whole operation.
// - Send-out neither reads nor writes the comparison buffer.
// - Range may cross rows and pages; buffer stays within zero page.
// - Single-byte send leaves range and result registers untouched.
module frv_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output frv_pkg::frv_flash_req_t flash_req,
  input wire logic [7:0] flash_rdata,
  input wire logic flash_rvalid,
  output frv_pkg::frv_buf_req_t buf_req,
  input wire logic [7:0] buf_rdata,
  input wire logic buf_rvalid,
  input wire logic link_in,
  output logic link_out,
  output logic link_oe,
  output logic wdog_kick,
  output logic irq_masked
);
  import frv_pkg::*;

  frv_state_t state_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [7:0] opt_q;
  logic [15:0] first_q;
  logic [15:0] last_q;
  logic [7:0] buf_base_q;
  logic pin_dir_q;
  logic pin_data_q;
  logic done_q;
  logic result_q;
  logic setup_err_q;
  logic [7:0] csum_q;
  logic [15:0] next_q;
  logic [15:0] addr_q;
  logic [7:0] idx_q;
  logic [7:0] byte_q;
  logic [7:0] txb_q;
  logic send_mode_q;
  frv_flash_req_t flash_q;
  frv_buf_req_t buf_q;
  logic [7:0] wd_cnt_q;
  logic wd_kick_q;
  logic pin_s1_q;
  logic pin_s2_q;
  logic out_q;
  logic oe_q;
  logic irqm_q;
  logic [9:0] tx_sh_q;
  logic [3:0] tx_bit_q;
  logic [7:0] tx_baud_q;
  logic tx_busy_q;
  logic acc;
  logic wr_acc;
  logic start_req;
  logic send_req;
  logic pin_ok;
  logic busy;
  logic fifo_in_valid;
  logic [7:0] fifo_in_data;
  logic fifo_in_ready;
  logic [7:0] fifo_out_data;
  logic fifo_out_valid;
  logic fifo_out_ready;

  function automatic logic [31:0] mask_be(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign acc = (avs_read || avs_write) && wait_q;
  assign wr_acc = avs_write && !wait_q;
  assign busy = (state_q != ST_IDLE);
  assign pin_ok = !pin_dir_q && !pin_data_q;
  assign start_req = wr_acc && (avs_address == REG_CTRL) && avs_byteenable[0]
                     && avs_writedata[CTRL_START_BIT];
  assign send_req = wr_acc && (avs_address == REG_CTRL) && avs_byteenable[0]
                    && avs_writedata[CTRL_SEND_BIT];

  // Bus handshake: every access answers one cycle after it appears
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !acc;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (avs_read && wait_q) begin
      unique case (avs_address)
        REG_CTRL: rdata_q <= {16'h0000, opt_q, 8'h00};
        REG_FIRST: rdata_q <= {16'h0000, first_q};
        REG_LAST: rdata_q <= {16'h0000, last_q};
        REG_BUF_BASE: rdata_q <= {24'h000000, buf_base_q};
        REG_PIN_CFG: rdata_q <= {30'h00000000, pin_data_q, pin_dir_q};
        REG_STATUS: rdata_q <= {16'h0000, csum_q, 3'h0, pin_s2_q,
                                setup_err_q, result_q, done_q, busy};
        REG_NEXT: rdata_q <= {16'h0000, next_q};
        default: rdata_q <= '0;
      endcase
    end
  end

  // Software-written configuration, frozen while the engine runs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      opt_q <= BYTE_RST;
      txb_q <= BYTE_RST;
      first_q <= ADDR_RST;
      last_q <= ADDR_RST;
      buf_base_q <= BYTE_RST;
      pin_dir_q <= 1'b0;
      pin_data_q <= 1'b0;
    end else if (wr_acc && !busy) begin
      unique case (avs_address)
        REG_CTRL: begin
          if (avs_byteenable[1]) begin
            opt_q <= avs_writedata[CTRL_OPT_LSB +: 8];
          end
          if (avs_byteenable[2]) begin
            txb_q <= avs_writedata[CTRL_TXB_LSB +: 8];
          end
        end
        REG_FIRST: first_q <= 16'(mask_be({16'h0000, first_q},
                                          avs_writedata, avs_byteenable));
        REG_LAST: last_q <= 16'(mask_be({16'h0000, last_q},
                                        avs_writedata, avs_byteenable));
        REG_BUF_BASE: begin
          if (avs_byteenable[0]) begin
            buf_base_q <= avs_writedata[7:0];
          end
        end
        REG_PIN_CFG: begin
          if (avs_byteenable[0]) begin
            pin_dir_q <= avs_writedata[PIN_DIR_BIT];
            pin_data_q <= avs_writedata[PIN_DATA_BIT];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Range engine
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      addr_q <= ADDR_RST;
      idx_q <= BYTE_RST;
      byte_q <= BYTE_RST;
      send_mode_q <= 1'b0;
      flash_q <= '0;
      buf_q <= '0;
      csum_q <= BYTE_RST;
      next_q <= ADDR_RST;
      result_q <= 1'b0;
      done_q <= 1'b0;
      setup_err_q <= 1'b0;
    end else begin
      flash_q.rd <= 1'b0;
      buf_q.rd <= 1'b0;
      buf_q.wr <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (start_req) begin
            send_mode_q <= (avs_byteenable[1] ?
                            avs_writedata[CTRL_OPT_LSB +: 8] : opt_q)
                           == OPT_SEND_OUT;
            if (((avs_byteenable[1] ? avs_writedata[CTRL_OPT_LSB +: 8]
                  : opt_q) == OPT_SEND_OUT) && !pin_ok) begin
              setup_err_q <= 1'b1;
            end else begin
              setup_err_q <= 1'b0;
              done_q <= 1'b0;
              addr_q <= first_q;
              idx_q <= BYTE_RST;
              csum_q <= BYTE_RST;
              result_q <= 1'b1;
              state_q <= ST_FLASH_RD;
            end
          end else if (send_req) begin
            if (!pin_ok) begin
              setup_err_q <= 1'b1;
            end else begin
              setup_err_q <= 1'b0;
              byte_q <= avs_byteenable[2] ?
                        avs_writedata[CTRL_TXB_LSB +: 8] : txb_q;
              state_q <= ST_SINGLE;
            end
          end
        end
        ST_FLASH_RD: begin
          flash_q.rd <= 1'b1;
          flash_q.addr <= addr_q;
          state_q <= ST_FLASH_WAIT;
        end
        ST_FLASH_WAIT: begin
          if (flash_rvalid) begin
            byte_q <= flash_rdata;
            csum_q <= 8'(csum_q + flash_rdata);
            state_q <= send_mode_q ? ST_PUSH : ST_BUF_RD;
          end
        end
        ST_BUF_RD: begin
          buf_q.rd <= 1'b1;
          buf_q.addr <= 8'(buf_base_q + idx_q);
          state_q <= ST_BUF_WAIT;
        end
        ST_BUF_WAIT: begin
          if (buf_rvalid) begin
            if (buf_rdata != byte_q) begin
              result_q <= 1'b0;
            end
            state_q <= ST_BUF_WR;
          end
        end
        ST_BUF_WR: begin
          buf_q.wr <= 1'b1;
          buf_q.wdata <= byte_q;
          state_q <= ST_NEXT;
        end
        ST_PUSH: begin
          if (fifo_in_ready) begin
            state_q <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          addr_q <= 16'(addr_q + 1'b1);
          idx_q <= 8'(idx_q + 1'b1);
          if (addr_q == last_q) begin
            next_q <= 16'(addr_q + 1'b1);
            state_q <= send_mode_q ? ST_DRAIN : ST_IDLE;
            done_q <= !send_mode_q;
            if (send_mode_q) begin
              result_q <= 1'b0;
            end
          end else begin
            state_q <= ST_FLASH_RD;
          end
        end
        ST_DRAIN: begin
          if (!fifo_out_valid && !tx_busy_q) begin
            done_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        ST_SINGLE: begin
          if (fifo_in_ready) begin
            state_q <= ST_SINGLE_DRAIN;
          end
        end
        ST_SINGLE_DRAIN: begin
          if (!fifo_out_valid && !tx_busy_q) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign fifo_in_valid = (state_q == ST_PUSH) || (state_q == ST_SINGLE);
  assign fifo_in_data = byte_q;
  assign fifo_out_ready = !tx_busy_q;

  frv_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_data(fifo_in_data),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready)
  );

  // Serial sender: start, eight data bits LSB first, stop
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_busy_q <= 1'b0;
      tx_sh_q <= '1;
      tx_bit_q <= '0;
      tx_baud_q <= '0;
    end else if (!tx_busy_q) begin
      if (fifo_out_valid) begin
        tx_busy_q <= 1'b1;
        tx_sh_q <= {1'b1, fifo_out_data, 1'b0};
        tx_bit_q <= '0;
        tx_baud_q <= '0;
      end
    end else if (tx_baud_q == BAUD_LAST) begin
      tx_baud_q <= '0;
      tx_sh_q <= {1'b1, tx_sh_q[9:1]};
      if (tx_bit_q == FRAME_LAST) begin
        tx_busy_q <= 1'b0;
      end else begin
        tx_bit_q <= 4'(tx_bit_q + 1'b1);
      end
    end else begin
      tx_baud_q <= 8'(tx_baud_q + 1'b1);
    end
  end

  // Open-drain drive: pull low for a zero bit, release for a one
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      out_q <= pin_dir_q ? pin_data_q : 1'b0;
      oe_q <= pin_dir_q || (tx_busy_q && !tx_sh_q[0]);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
    end else begin
      pin_s1_q <= link_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Watchdog service while a range operation runs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wd_cnt_q <= WDOG_FIRST;
      wd_kick_q <= 1'b0;
    end else if (!busy || state_q == ST_SINGLE
                 || state_q == ST_SINGLE_DRAIN) begin
      wd_cnt_q <= WDOG_FIRST;
      wd_kick_q <= 1'b0;
    end else if (wd_cnt_q == 8'h00) begin
      wd_cnt_q <= WDOG_PERIOD;
      wd_kick_q <= 1'b1;
    end else begin
      wd_cnt_q <= 8'(wd_cnt_q - 1'b1);
      wd_kick_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irqm_q <= 1'b0;
    end else begin
      irqm_q <= 1'b0;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign flash_req = flash_q;
  assign buf_req = buf_q;
  assign link_out = out_q;
  assign link_oe = oe_q;
  assign wdog_kick = wd_kick_q;
  assign irq_masked = irqm_q;
endmodule

// *** test/frv_asserts.sv ***
// Port-level checker of the flash range verify block
`timescale 1ns/1ns
module frv_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire frv_pkg::frv_flash_req_t flash_req,
  input wire logic [7:0] flash_rdata,
  input wire logic flash_rvalid,
  input wire frv_pkg::frv_buf_req_t buf_req,
  input wire logic link_out,
  input wire logic link_oe,
  input wire logic wdog_kick,
  input wire logic irq_masked
);
  import frv_pkg::*;
  logic start_w, kicked_q, seen_q, oe_q;
  logic [7:0] cnt_q, fl_q, brd_q;
  logic [15:0] run_q, addr_q;
  assign start_w = avs_write && !avs_waitrequest && avs_address == REG_CTRL
    && avs_writedata[CTRL_START_BIT];
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Cycles since start or since the last service pulse
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
      kicked_q <= 1'b0;
    end else if (start_w) begin
      cnt_q <= 8'h00;
      kicked_q <= 1'b0;
    end else if (wdog_kick) begin
      cnt_q <= 8'h00;
      kicked_q <= 1'b1;
    end else if (cnt_q != 8'hFF) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      seen_q <= 1'b0;
      addr_q <= ADDR_RST;
    end else if (start_w) begin
      seen_q <= 1'b0;
    end else if (flash_req.rd) begin
      seen_q <= 1'b1;
      addr_q <= flash_req.addr;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fl_q <= BYTE_RST;
      brd_q <= BYTE_RST;
    end else begin
      if (flash_rvalid)
        fl_q <= flash_rdata;
      if (buf_req.rd)
        brd_q <= buf_req.addr;
    end
  end
  // Length of the current pin level run
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      oe_q <= 1'b0;
      run_q <= 16'h0000;
    end else begin
      oe_q <= link_oe;
      run_q <= (link_oe != oe_q) ? 16'h0000 : run_q + 16'h0001;
    end
  end
  AST_IRQ_OPEN: assert property (!irq_masked)
    else $error("interrupts masked");
  AST_BUS_ANSWER: assert property ($rose(avs_read || avs_write)
    |=> !avs_waitrequest) else $error("bus answer late");
  AST_BUS_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  AST_PIN_DRIVE: assert property (link_oe |-> !link_out)
    else $error("pin driven high");
  AST_BIT_TIME: assert property ($fell(link_oe) |->
    run_q[7:0] == BAUD_LAST && run_q < 16'd2304)
    else $error("low run not whole bits");
  AST_WDOG_TIME: assert property (wdog_kick |-> (kicked_q ?
    cnt_q == WDOG_PERIOD : (cnt_q >= 8'd22 && cnt_q <= 8'd24)))
    else $error("watchdog service mistimed");
  AST_WDOG_PULSE: assert property (wdog_kick |=> !wdog_kick)
    else $error("watchdog pulse too long");
  AST_FLASH_ASCEND: assert property (flash_req.rd && seen_q |->
    flash_req.addr == addr_q + 16'h0001) else $error("flash order");
  AST_WRITE_BACK: assert property (buf_req.wr |->
    buf_req.wdata == fl_q && buf_req.addr == brd_q)
    else $error("buffer write back wrong");
  AST_FLASH_PULSE: assert property (flash_req.rd |=> !flash_req.rd)
    else $error("flash read pulse too long");
endmodule

// *** test/frv_host_model.sv ***
// Serial host that takes bytes off the pulled-up link pin
`timescale 1ns/1ns
module frv_host_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pin,
  output logic [7:0] byte_o,
  output logic valid_o,
  output logic ferr_o
);
  import frv_pkg::*;
  logic [7:0] sh;
  logic bad;
  int i;
  initial begin
    byte_o = 8'h00;
    valid_o = 1'b0;
    ferr_o = 1'b0;
  end
  always begin
    @(posedge clk_sys);
    valid_o <= 1'b0;
    if (!rst && pin === 1'b0) begin
      repeat (BAUD_DIV / 2 - 1) @(posedge clk_sys);
      bad = (pin !== 1'b0);
      for (i = 0; i < 8; i++) begin
        repeat (BAUD_DIV) @(posedge clk_sys);
        sh[i] = pin;
      end
      repeat (BAUD_DIV) @(posedge clk_sys);
      ferr_o <= bad || pin !== 1'b1;
      byte_o <= sh;
      valid_o <= 1'b1;
    end
  end
endmodule

// *** test/frv_top_tb_top.sv ***
// Self-checking bench of the flash range verify block
`timescale 1ns/1ns
module frv_top_tb_top;
  import frv_pkg::*;
  logic clk_sys = 1'b0;
  logic rst, avs_read, avs_write, avs_waitrequest, link_out, link_oe;
  logic wdog_kick, irq_masked, fl_rvalid, bf_rvalid, pin, h_valid, h_ferr;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdv;
  logic [3:0] avs_byteenable;
  logic [7:0] fl_rdata, bf_rdata, h_byte;
  logic [7:0] bmem [256];
  frv_flash_req_t flash_req;
  frv_buf_req_t buf_req;
  logic [63:0] rd_q [$];
  logic [7:0] ser_q [$];
  logic [31:0] seed = 32'hA8DE;
  int n_fail = 0;
  int samples_checked = 0;
  int n_fl = 0;
  int n_buf = 0;
  always #5 clk_sys = ~clk_sys;
  assign pin = link_oe ? link_out : 1'b1;
  frv_top i_dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .flash_req(flash_req), .flash_rdata(fl_rdata), .flash_rvalid(fl_rvalid),
    .buf_req(buf_req), .buf_rdata(bf_rdata), .buf_rvalid(bf_rvalid),
    .link_in(pin), .link_out(link_out), .link_oe(link_oe),
    .wdog_kick(wdog_kick), .irq_masked(irq_masked));
  frv_host_model i_host (.clk_sys(clk_sys), .rst(rst), .pin(pin),
    .byte_o(h_byte), .valid_o(h_valid), .ferr_o(h_ferr));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] fval(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic fail_out();
    n_fail++;
    wrap_up();
  endtask
  // One bus access; on reads d is the expectation under mask m
  task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d,
                     input logic [31:0] m);
    int k;
    k = 0;
    if (!w)
      rd_q.push_back({m, d & m});
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    rdv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 50)
      fail_out();
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, 32'h0);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    bus(a, 1'b0, e, m);
  endtask
  task automatic wait_idle();
    int k;
    for (k = 0; k < 600; k++) begin
      repeat (200) @(posedge clk_sys);
      rd(REG_STATUS, 32'h0, 32'h0);
      if (rdv[ST_BUSY_BIT] === 1'b0)
        return;
    end
    fail_out();
  endtask
  task automatic run_op(input logic [15:0] f, input logic [15:0] l,
                        input logic [7:0] opt);
    wr(REG_FIRST, {16'h0, f});
    wr(REG_LAST, {16'h0, l});
    wr(REG_CTRL, {16'h0, opt, 8'h01});
  endtask
  // Flash and zero-page buffer answer one cycle after each pulse
  always @(posedge clk_sys) begin
    fl_rvalid <= flash_req.rd;
    fl_rdata <= fval(flash_req.addr);
    bf_rvalid <= buf_req.rd;
    bf_rdata <= bmem[buf_req.addr];
    if (buf_req.wr === 1'b1)
      bmem[buf_req.addr] <= buf_req.wdata;
    if (flash_req.rd === 1'b1)
      n_fl++;
    if (buf_req.rd === 1'b1 || buf_req.wr === 1'b1)
      n_buf++;
  end
  always @(posedge clk_sys) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      chk(avs_readdata & rd_q[0][63:32], rd_q[0][31:0]);
      void'(rd_q.pop_front());
    end
    if (h_valid === 1'b1)
      chk({23'h0, h_ferr, h_byte}, {24'h0, ser_q.pop_front()});
  end
  initial begin
    logic [31:0] r;
    logic [15:0] f;
    logic [7:0] base, opt, cs;
    int t, i, nf, nb, k;
    rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(REG_STATUS, 32'h0, 32'hFFFFFFEF);
    rd(REG_PIN_CFG, 32'h0, 32'h3);
    rd(REG_NEXT, 32'h0, 32'hFFFFFFFF);
    rd(5'h1C, 32'h0, 32'hFFFFFFFF);
    for (t = 0; t < 2; t++) begin
      r = rnd();
      f = {r[7:0], 8'hF8};
      base = r[15:8];
      opt = t ? 8'hFF : (r[23:16] | 8'h01);
      cs = 8'h00;
      for (i = 0; i < 17; i++) begin
        bmem[8'(base + i)] = fval(f + 16'(i));
        cs += fval(f + 16'(i));
      end
      if (t)
        bmem[8'(base + 5)] ^= 8'h01;
      wr(REG_BUF_BASE, {24'h0, base});
      run_op(f, f + 16'h0010, opt);
      wait_idle();
      rd(REG_STATUS, {16'h0, cs, t ? 8'h12 : 8'h16}, 32'hFFFFFFFF);
      rd(REG_NEXT, {16'h0, f + 16'h0011}, 32'hFFFFFFFF);
      for (i = 0; i < 17; i++)
        chk({24'h0, bmem[8'(base + i)]}, {24'h0, fval(f + 16'(i))});
    end
    wr(REG_PIN_CFG, 32'h2);
    wr(REG_CTRL, 32'h2);
    rd(REG_STATUS, 32'h8, 32'h9);
    // Send-out start with the data latch set is refused too
    wr(REG_CTRL, 32'h1);
    rd(REG_STATUS, 32'h8, 32'h9);
    wr(REG_PIN_CFG, 32'h0);
    r = rnd();
    ser_q.push_back(r[7:0]);
    wr(REG_CTRL, {8'h00, r[7:0], 16'h0002});
    wait_idle();
    rd(REG_STATUS, {16'h0, cs, 8'h12}, 32'hFFFFFFF7);
    rd(REG_NEXT, {16'h0, f + 16'h0011}, 32'hFFFFFFFF);
    for (i = 0; i < 3000 && ser_q.size() != 0; i++)
      @(posedge clk_sys);
    chk(32'(ser_q.size()), 32'h0);
    nf = n_fl;
    nb = n_buf;
    r = rnd();
    f = r[15:0];
    cs = 8'h00;
    for (i = 0; i < 35; i++) begin
      ser_q.push_back(fval(f + 16'(i)));
      cs += fval(f + 16'(i));
    end
    run_op(f, f + 16'h0022, OPT_SEND_OUT);
    repeat (1000) @(posedge clk_sys);
    // Full FIFO, one frame in the sender and one byte held back
    chk(32'(n_fl - nf), 32'(FIFO_DEPTH + 2));
    // Host watchdog with a two-period timeout must never expire
    k = 0;
    for (i = 0; i < 2 * WDOG_PERIOD_CYC; i++) begin
      @(posedge clk_sys);
      k += int'(wdog_kick);
    end
    chk(32'(k), 32'h2);
    wait_idle();
    chk(32'(n_buf - nb), 32'h0);
    rd(REG_STATUS, {16'h0, cs, 8'h12}, 32'hFFFFFFF3);
    rd(REG_NEXT, {16'h0, f + 16'h0023}, 32'hFFFFFFFF);
    chk(32'(ser_q.size()), 32'h0);
    wrap_up();
  end
endmodule
bind frv_top frv_asserts i_chk (.clk_sys(clk_sys), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .flash_req(flash_req), .flash_rdata(flash_rdata),
  .flash_rvalid(flash_rvalid), .buf_req(buf_req), .link_out(link_out),
  .link_oe(link_oe), .wdog_kick(wdog_kick), .irq_masked(irq_masked));
